/* pzps_far_side.sv */
// far side model: processor power-state pins and reference drop sense
`timescale 1ns/1ps
module pzps_far_side
    import pzps_pkg::*;
(
    // clock
    input  wire logic       i_clock,
    // commands from the bench
    input  wire logic [1:0] i_psi_level,
    input  wire logic       i_drop,
    // pins toward the controller
    output logic            o_psi_high,
    output logic            o_psi_low,
    output logic            o_fast_drop
);
    logic [2:0] drop_cnt_r = 3'h0;
    // three-level input carried as two pins, high wins
    assign o_psi_high  = (i_psi_level == 2'h2);
    assign o_psi_low   = (i_psi_level == 2'h0);
    assign o_fast_drop = (drop_cnt_r != 3'h0);
    // stretch a drop event so the synchroniser cannot miss it
    always_ff @(posedge i_clock) begin
        drop_cnt_r <= i_drop ? 3'h4 : drop_cnt_r - 3'(drop_cnt_r != 3'h0);
    end
endmodule

/* pzps_phase_map.sv */
// zone and phase count to phase drive enable mask
`timescale 1ns/1ps
module pzps_phase_map
    import pzps_pkg::*;
(
    // selection
    input  wire logic [2:0] i_phase_idx,
    input  wire logic [2:0] i_zone,
    // result
    output logic      [7:0] o_mask,
    output logic      [7:0] o_all_mask,
    output logic      [4:0] o_zone_ok
);

    always_comb begin
        o_zone_ok  = PZPS_ZONE_OK[i_phase_idx];
        o_all_mask = PZPS_MASK[i_phase_idx][0];
        if (i_zone > PZPS_ZONE_MAX) begin
            o_mask = o_all_mask;
        end else begin
            o_mask = PZPS_MASK[i_phase_idx][i_zone];
        end
    end

endmodule

/* pzps_pkg.sv */
// constants, register map and zone tables for the power zone phase shedding block
package pzps_pkg;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int PZPS_CLK_PERIOD_NS  = 4;
    localparam int PZPS_SAMPLE_US      = 10;
    localparam int PZPS_SAMPLE_CYC     = PZPS_SAMPLE_US * 1000 / PZPS_CLK_PERIOD_NS;
    localparam int PZPS_SHED_STEP_US   = 10;
    localparam int PZPS_SHED_STEP_CYC  = PZPS_SHED_STEP_US * 1000 / PZPS_CLK_PERIOD_NS;
    localparam int PZPS_SHED_DELAY_US  = 200;
    localparam int PZPS_BOOST_MS       = 2;
    localparam int PZPS_BOOST_CYC      = PZPS_BOOST_MS * 1000000 / PZPS_CLK_PERIOD_NS;

    // ------------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] PZPS_REG_FAST_DROP = 8'h31;
    localparam logic [7:0] PZPS_REG_LOAD_LINE = 8'h39;
    localparam logic [7:0] PZPS_REG_THR_BASE  = 8'h40;
    localparam logic [7:0] PZPS_REG_HYST      = 8'h44;
    localparam logic [7:0] PZPS_REG_SHED_DLY  = 8'h45;
    localparam logic [7:0] PZPS_REG_FSW       = 8'h46;
    localparam logic [7:0] PZPS_REG_LPC       = 8'h47;
    localparam logic [7:0] PZPS_REG_STATUS    = 8'h48;

    // ------------------------------------------------------------------
    // reset values and fields
    // ------------------------------------------------------------------
    localparam logic [7:0] PZPS_THR_DISABLED  = 8'hFF;
    localparam logic [7:0] PZPS_HYST_RST      = 8'h44;
    localparam logic [7:0] PZPS_SHED_DLY_RST  = 8'(PZPS_SHED_DELAY_US / PZPS_SHED_STEP_US);
    localparam logic [7:0] PZPS_ZERO_BYTE     = 8'h00;
    localparam logic [2:0] PZPS_LPC_RST       = 3'h0;
    localparam int         PZPS_FAST_DROP_EN  = 0;
    localparam int         PZPS_LL_EN_BIT     = 7;
    localparam logic [7:0] PZPS_DROOP_0       = 8'h00;
    localparam logic [7:0] PZPS_DROOP_25      = 8'h19;
    localparam logic [7:0] PZPS_DROOP_50      = 8'h32;
    localparam logic [7:0] PZPS_DROOP_100     = 8'h64;

    // ------------------------------------------------------------------
    // zones
    // ------------------------------------------------------------------
    localparam int         PZPS_NZONES        = 5;
    localparam int         PZPS_NTHR          = 4;
    localparam logic [2:0] PZPS_ZONE_ALL      = 3'h0;
    localparam logic [2:0] PZPS_ZONE_MAX      = 3'h4;
    localparam logic [2:0] PZPS_ZONE_SINGLE   = 3'h3;

    typedef enum logic [1:0] {
        PZPS_MODE_FIXED,
        PZPS_MODE_AUTO,
        PZPS_MODE_ALL
    } pzps_mode_t;

    // enable masks per phase count (index = phases - 1) and zone; bit 0 drives output 1
    localparam logic [7:0] PZPS_MASK [0:7][0:4] = '{
        '{8'h01, 8'h01, 8'h01, 8'h01, 8'h01},
        '{8'h03, 8'h01, 8'h01, 8'h01, 8'h01},
        '{8'h07, 8'h01, 8'h01, 8'h01, 8'h01},
        '{8'h0F, 8'h01, 8'h05, 8'h01, 8'h01},
        '{8'h1F, 8'h01, 8'h01, 8'h01, 8'h01},
        '{8'h3F, 8'h01, 8'h15, 8'h01, 8'h01},
        '{8'h7F, 8'h5D, 8'h49, 8'h01, 8'h01},
        '{8'hFF, 8'h55, 8'h11, 8'h01, 8'h01}
    };

    // zones offered per phase count, bit z set when zone z exists
    localparam logic [4:0] PZPS_ZONE_OK [0:7] = '{
        5'h11, 5'h19, 5'h19, 5'h1D, 5'h19, 5'h1D, 5'h1F, 5'h1F
    };

endpackage

/* pzps_sync.sv */
// two flip-flop synchroniser for asynchronous pin levels
`timescale 1ns/1ps
module pzps_sync
    import pzps_pkg::*;
#(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         i_clock,
    input  wire logic         i_rst,
    // levels
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_sync
);

    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } pzps_sync_t;

    pzps_sync_t s_r;
    pzps_sync_t s_nxt;

    always_comb begin
        s_nxt        = s_r;
        s_nxt.meta   = i_async;
        s_nxt.stable = s_r.meta;
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign o_sync = s_r.stable;

endmodule

/* pzps_zone_ctrl.sv */
// power zone selection, stepped shedding and phase drive enables
`timescale 1ns/1ps
module pzps_zone_ctrl
    import pzps_pkg::*;
#(
    parameter int BOOST_CYC = PZPS_BOOST_CYC
) (
    // clock and reset
    input  wire logic       i_clock,
    input  wire logic       i_rst,
    // register port
    input  wire logic       i_reg_wr,
    input  wire logic [7:0] i_reg_addr,
    input  wire logic [7:0] i_reg_wdata,
    output logic      [7:0] o_reg_rdata,
    // pins
    input  wire logic       i_power_saving_input_high,
    input  wire logic       i_power_saving_input_low,
    input  wire logic       i_vout_nominal,
    input  wire logic       i_reference_input_fast_drop,
    input  wire logic [3:0] i_phase_count,
    // converter data
    input  wire logic [7:0] i_iout_code,
    input  wire logic [7:0] i_fsw_strap,
    // outputs
    output logic      [7:0] o_phase_drive_output_en,
    output logic      [2:0] o_zone,
    output logic            o_all_phase_boost,
    output logic      [1:0] o_load_line_coefficient,
    output logic      [7:0] o_droop_pct,
    output logic      [7:0] o_switching_frequency_setting
);

    localparam int BW = $clog2(BOOST_CYC + 1);
    localparam int PW = $clog2(PZPS_SHED_STEP_CYC);
    localparam int TW = $clog2(PZPS_SAMPLE_CYC);

    typedef struct packed {
        logic [PZPS_NTHR-1:0][7:0] thr;
        logic [7:0]               hyst;
        logic [7:0]               dly;
        logic [7:0]               switching_frequency_setting;
        logic                     fsw_ovr;
        logic [7:0]               fsw_out;
        logic [2:0]               lpc;
        logic [7:0]               frd;
        logic [7:0]               ll;
        logic [7:0]               droop;
        pzps_mode_t               mode;
        logic [2:0]               zone;
        logic [2:0]               tgt;
        logic [TW-1:0]            tick;
        logic [PW-1:0]            pre;
        logic [7:0]               steps;
        logic [BW-1:0]            boost;
        logic                     boost_on;
        logic                     ref_prev;
        logic [7:0]               en;
        logic [7:0]               rdata;
    } pzps_state_t;

    pzps_state_t s_r;
    pzps_state_t s_nxt;

    logic [7:0] pins_s;
    logic       psi_hi_s;
    logic       psi_lo_s;
    logic       vnom_s;
    logic       ref_s;
    logic [3:0] pcount_s;
    logic [2:0] phase_idx;
    logic [7:0] zone_mask;
    logic [7:0] all_mask;
    logic [4:0] zone_ok;
    logic [4:0] auto_en;
    logic [4:0] en_set;
    logic [2:0] auto_tgt;
    logic [2:0] lpc_tgt;
    logic [2:0] nxt_dn;
    logic [2:0] nxt_up;
    logic       tick_fire;
    logic       boost_fire;

    // ------------------------------------------------------------------
    // pin synchronisers and phase map
    // ------------------------------------------------------------------
    pzps_sync #(
        .W (8)
    ) u_sync (
        .i_clock (i_clock),
        .i_rst   (i_rst),
        .i_async ({i_phase_count, i_reference_input_fast_drop, i_vout_nominal,
                   i_power_saving_input_low, i_power_saving_input_high}),
        .o_sync  (pins_s)
    );

    assign psi_hi_s = pins_s[0];
    assign psi_lo_s = pins_s[1];
    assign vnom_s   = pins_s[2];
    assign ref_s    = pins_s[3];
    assign pcount_s = pins_s[7:4];
    assign phase_idx = (pcount_s == 4'h0 || pcount_s > 4'h8) ? 3'h0 : 3'(pcount_s - 4'h1);

    pzps_phase_map u_map (
        .i_phase_idx (phase_idx),
        .i_zone      (s_r.zone),
        .o_mask      (zone_mask),
        .o_all_mask  (all_mask),
        .o_zone_ok   (zone_ok)
    );

    // ------------------------------------------------------------------
    // zone sets and targets
    // ------------------------------------------------------------------
    always_comb begin
        logic [7:0] bnd;
        logic [7:0] lim;
        logic       hit;
        bnd      = PZPS_ZERO_BYTE;
        lim      = PZPS_ZERO_BYTE;
        hit      = 1'b0;
        auto_en  = zone_ok;
        auto_tgt = PZPS_ZONE_ALL;
        lpc_tgt  = PZPS_ZONE_ALL;
        for (int z = 1; z < PZPS_NZONES; z++) begin
            bnd = s_r.thr[PZPS_NTHR-z];
            if (bnd == PZPS_THR_DISABLED) begin
                auto_en[z] = 1'b0;
            end
            lim = (bnd > s_r.hyst) ? 8'(bnd - s_r.hyst) : PZPS_ZERO_BYTE;
            if (3'(z) <= s_r.zone) begin
                hit = (i_iout_code <= bnd);
            end else begin
                hit = (i_iout_code < lim);
            end
            if (auto_en[z] && hit) begin
                auto_tgt = 3'(z);
            end
        end
        for (int z = 0; z < PZPS_NZONES; z++) begin
            if (zone_ok[z] && 3'(z) <= s_r.lpc) begin
                lpc_tgt = 3'(z);
            end
        end
        en_set = auto_en;
        if (s_r.mode == PZPS_MODE_FIXED) begin
            en_set[lpc_tgt] = 1'b1;
        end
        nxt_dn = PZPS_ZONE_ALL;
        nxt_up = s_r.zone;
        for (int z = 0; z < PZPS_NZONES; z++) begin
            if (en_set[z] && 3'(z) < s_r.zone) begin
                nxt_dn = 3'(z);
            end
        end
        for (int z = PZPS_NZONES - 1; z >= 0; z--) begin
            if (en_set[z] && 3'(z) > s_r.zone && 3'(z) <= s_r.tgt) begin
                nxt_up = 3'(z);
            end
        end
    end

    assign tick_fire  = (s_r.tick == TW'(PZPS_SAMPLE_CYC - 1));
    assign boost_fire = s_r.frd[PZPS_FAST_DROP_EN] && ref_s && !s_r.ref_prev
                        && (s_r.zone >= PZPS_ZONE_SINGLE);

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;

        // register writes
        if (i_reg_wr) begin
            case (i_reg_addr)
                PZPS_REG_FAST_DROP: s_nxt.frd = i_reg_wdata;
                PZPS_REG_LOAD_LINE: s_nxt.ll = i_reg_wdata;
                PZPS_REG_HYST:      s_nxt.hyst = i_reg_wdata;
                PZPS_REG_SHED_DLY:  s_nxt.dly = i_reg_wdata;
                PZPS_REG_LPC:       s_nxt.lpc = i_reg_wdata[2:0];
                PZPS_REG_FSW: begin
                    s_nxt.switching_frequency_setting     = i_reg_wdata;
                    s_nxt.fsw_ovr = 1'b1;
                end
                default: begin
                end
            endcase
            for (int k = 0; k < PZPS_NTHR; k++) begin
                if (i_reg_addr == 8'(PZPS_REG_THR_BASE + 8'(k))) begin
                    s_nxt.thr[k] = i_reg_wdata;
                end
            end
        end

        // register reads, answered one cycle after the address
        case (i_reg_addr)
            PZPS_REG_FAST_DROP: s_nxt.rdata = s_r.frd;
            PZPS_REG_LOAD_LINE: s_nxt.rdata = s_r.ll;
            PZPS_REG_HYST:      s_nxt.rdata = s_r.hyst;
            PZPS_REG_SHED_DLY:  s_nxt.rdata = s_r.dly;
            PZPS_REG_FSW:       s_nxt.rdata = s_r.fsw_out;
            PZPS_REG_LPC:       s_nxt.rdata = {5'h00, s_r.lpc};
            PZPS_REG_STATUS:    s_nxt.rdata = {2'h0, s_r.boost_on, s_r.mode, s_r.zone};
            default:            s_nxt.rdata = PZPS_ZERO_BYTE;
        endcase
        for (int k = 0; k < PZPS_NTHR; k++) begin
            if (i_reg_addr == 8'(PZPS_REG_THR_BASE + 8'(k))) begin
                s_nxt.rdata = s_r.thr[k];
            end
        end

        // mode from the power saving input level
        if (psi_hi_s) begin
            s_nxt.mode = PZPS_MODE_ALL;
        end else if (psi_lo_s) begin
            s_nxt.mode = PZPS_MODE_FIXED;
        end else begin
            s_nxt.mode = PZPS_MODE_AUTO;
        end

        // current monitor sample tick
        s_nxt.tick = tick_fire ? '0 : TW'(s_r.tick + 1'b1);

        // target zone
        case (s_r.mode)
            PZPS_MODE_FIXED: s_nxt.tgt = lpc_tgt;
            PZPS_MODE_AUTO: begin
                if (!vnom_s) begin
                    s_nxt.tgt = PZPS_ZONE_ALL;
                end else if (tick_fire) begin
                    s_nxt.tgt = auto_tgt;
                end
            end
            PZPS_MODE_ALL: s_nxt.tgt = PZPS_ZONE_ALL;
            default:       s_nxt.tgt = PZPS_ZONE_ALL;
        endcase

        // stepping, shared by fixed and automatic modes
        if (s_r.tgt < s_r.zone) begin
            s_nxt.zone  = nxt_dn;
            s_nxt.pre   = '0;
            s_nxt.steps = PZPS_ZERO_BYTE;
        end else if (s_r.tgt > s_r.zone) begin
            if (s_r.steps >= s_r.dly) begin
                s_nxt.zone  = nxt_up;
                s_nxt.pre   = '0;
                s_nxt.steps = PZPS_ZERO_BYTE;
            end else if (s_r.pre == PW'(PZPS_SHED_STEP_CYC - 1)) begin
                s_nxt.pre   = '0;
                s_nxt.steps = 8'(s_r.steps + 8'h01);
            end else begin
                s_nxt.pre = PW'(s_r.pre + 1'b1);
            end
        end else begin
            s_nxt.pre   = '0;
            s_nxt.steps = PZPS_ZERO_BYTE;
        end

        // fast reference drop boost window
        s_nxt.ref_prev = ref_s;
        if (boost_fire) begin
            s_nxt.boost = BW'(BOOST_CYC);
        end else if (s_r.boost != '0) begin
            s_nxt.boost = BW'(s_r.boost - 1'b1);
        end
        s_nxt.boost_on = (s_nxt.boost != '0);
        s_nxt.en       = s_nxt.boost_on ? all_mask : zone_mask;

        // load line and switching frequency
        if (s_r.ll[PZPS_LL_EN_BIT]) begin
            case (s_r.ll[1:0])
                2'h0:    s_nxt.droop = PZPS_DROOP_0;
                2'h1:    s_nxt.droop = PZPS_DROOP_25;
                2'h2:    s_nxt.droop = PZPS_DROOP_50;
                default: s_nxt.droop = PZPS_DROOP_100;
            endcase
        end else begin
            s_nxt.droop = PZPS_DROOP_0;
        end
        s_nxt.fsw_out = s_r.fsw_ovr ? s_r.switching_frequency_setting : i_fsw_strap;
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            s_r          <= '0;
            s_r.thr      <= {PZPS_NTHR{PZPS_THR_DISABLED}};
            s_r.hyst     <= PZPS_HYST_RST;
            s_r.dly      <= PZPS_SHED_DLY_RST;
            s_r.lpc      <= PZPS_LPC_RST;
            s_r.mode     <= PZPS_MODE_ALL;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign o_reg_rdata                   = s_r.rdata;
    assign o_phase_drive_output_en       = s_r.en;
    assign o_zone                        = s_r.zone;
    assign o_all_phase_boost             = s_r.boost_on;
    assign o_load_line_coefficient       = s_r.ll[1:0];
    assign o_droop_pct                   = s_r.droop;
    assign o_switching_frequency_setting = s_r.fsw_out;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_rst);

    a_out_mask: assert property (!s_nxt.boost_on |=> o_phase_drive_output_en == $past(zone_mask))
        else $error("phase enables do not follow zone mask");
    a_down_now: assert property ((s_r.tgt < s_r.zone) |=> (s_r.zone < $past(s_r.zone)))
        else $error("zone did not step down at once");
    a_up_delay: assert property ((s_nxt.zone > s_r.zone) |-> (s_r.steps >= s_r.dly))
        else $error("zone stepped up before shed delay");
    a_one_step: assert property ((s_nxt.zone != s_r.zone) |-> (s_nxt.zone == nxt_dn || s_nxt.zone == nxt_up))
        else $error("zone skipped an enabled intermediate zone");
    a_skip_off: assert property ((s_nxt.zone != s_r.zone) |-> en_set[s_nxt.zone])
        else $error("zone moved into a disabled zone");
    a_hyst_wr: assert property ((i_reg_wr && i_reg_addr == PZPS_REG_HYST) |=> s_r.hyst == $past(i_reg_wdata))
        else $error("hysteresis write lost");
    a_high_all: assert property ((s_r.mode == PZPS_MODE_ALL) |=> (s_r.tgt == PZPS_ZONE_ALL))
        else $error("high input did not target zone 0");
    a_boost_go: assert property (boost_fire |=> (o_all_phase_boost && o_phase_drive_output_en == $past(all_mask)))
        else $error("fast drop did not enable all phases");
    a_auto_gate: assert property ((s_r.mode == PZPS_MODE_AUTO && !vnom_s) |=> (s_r.tgt == PZPS_ZONE_ALL))
        else $error("shedding active before nominal output");
    a_ll_off: assert property (!s_r.ll[PZPS_LL_EN_BIT] |=> (o_droop_pct == PZPS_DROOP_0))
        else $error("droop applied with load line off");
    a_sample: assert property ((s_r.mode == PZPS_MODE_AUTO && vnom_s && tick_fire) |=> s_r.tgt == $past(auto_tgt))
        else $error("auto target not taken at sample tick");

endmodule

/* test_power_zone_phase_shedding.sv */
// self-checking bench for the power zone controller
`timescale 1ns/1ps
module test_power_zone_phase_shedding
    import pzps_pkg::*;
;
    // ------------------------------------------------------------------
    // signals
    // ------------------------------------------------------------------
    logic       i_clock = 1'b0;
    logic       i_rst   = 1'b1;
    logic       wr      = 1'b0;
    logic       vnom    = 1'b0;
    logic       drop    = 1'b0;
    logic       mon     = 1'b0;
    logic [7:0] addr    = 8'h00;
    logic [7:0] wdata   = 8'h00;
    logic [7:0] iout    = 8'h00;
    logic [7:0] strap   = 8'h00;
    logic [3:0] pcnt    = 4'h8;
    logic [1:0] power_saving_input     = 2'h2;
    logic [2:0] zone_q  = 3'h0;
    logic [7:0] rdata, en, droop, switching_frequency_setting;
    logic [2:0] zone;
    logic [1:0] coef;
    logic       boost, ps_h, ps_l, fdrop;
    int         failures = 0;
    int         samples_checked = 0;
    int         gap;
    logic [7:0] ra [10] = '{8'h31, 8'h39, 8'h40, 8'h41, 8'h42, 8'h43, 8'h44, 8'h45, 8'h47, 8'h50};
    logic [7:0] rv [10] = '{8'h00, 8'h00, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h44, 8'h14, 8'h00, 8'h00};
    logic [7:0] dpct [4] = '{8'h00, 8'h19, 8'h32, 8'h64};

    always #2 i_clock = ~i_clock;

    pzps_far_side far (.i_clock(i_clock), .i_psi_level(power_saving_input), .i_drop(drop),
        .o_psi_high(ps_h), .o_psi_low(ps_l), .o_fast_drop(fdrop));

    pzps_zone_ctrl #(.BOOST_CYC(50)) dut (.i_clock(i_clock), .i_rst(i_rst), .i_reg_wr(wr),
        .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
        .i_power_saving_input_high(ps_h), .i_power_saving_input_low(ps_l),
        .i_vout_nominal(vnom), .i_reference_input_fast_drop(fdrop), .i_phase_count(pcnt),
        .i_iout_code(iout), .i_fsw_strap(strap), .o_phase_drive_output_en(en), .o_zone(zone),
        .o_all_phase_boost(boost), .o_load_line_coefficient(coef), .o_droop_pct(droop),
        .o_switching_frequency_setting(switching_frequency_setting));

    // ------------------------------------------------------------------
    // reference model and checks
    // ------------------------------------------------------------------
    function automatic logic [2:0] mdl_zone(int p, int z);
        for (int k = z; k > 0; k--) begin
            if (k == 4 || (k == 3 && p > 1) || (k == 2 && p inside {4, 6, 7, 8}) || (k == 1 && p > 6))
                return 3'(k);
        end
        return 3'h0;
    endfunction

    function automatic logic [7:0] mdl_mask(int p, logic [2:0] z);
        case (z)
            3'h0: return 8'((1 << p) - 1);
            3'h1: return (p == 8) ? 8'h55 : 8'h5D;
            3'h2: return (p == 8) ? 8'h11 : (p == 7) ? 8'h49 : (p == 6) ? 8'h15 : 8'h05;
            default: return 8'h01;
        endcase
    endfunction

    task automatic chk_pin(logic [15:0] got, logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: output %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_reg(logic [7:0] got, logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: register %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cyc(int n);
        repeat (n) @(negedge i_clock);
    endtask

    task automatic wr_reg(logic [7:0] a, logic [7:0] d);
        @(negedge i_clock);
        wr = 1'b1;
        addr = a;
        wdata = d;
        @(negedge i_clock);
        wr = 1'b0;
    endtask

    task automatic rd_reg(logic [7:0] a, logic [7:0] exp);
        @(negedge i_clock);
        addr = a;
        @(negedge i_clock);
        chk_reg(rdata, exp);
    endtask

    task automatic wait_zone(logic [2:0] z, int lim);
        int k = 0;
        while (zone !== z && k < lim) begin
            @(negedge i_clock);
            k++;
        end
        if (zone !== z) begin
            failures++;
            $display("wrong value at %0t: zone wait timed out", $time);
        end
    endtask

    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // zone moves one step at a time while every threshold is enabled
    always @(negedge i_clock) begin
        if (mon && !i_rst && zone !== zone_q)
            chk_pin(16'((zone > zone_q) ? zone - zone_q : zone_q - zone), 16'h0001);
        zone_q = zone;
    end

    initial begin
        repeat (60000) @(posedge i_clock);
        failures++;
        complete_run;
    end

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    initial begin
        void'($urandom(32377));
        strap = 8'($urandom);
        cyc(3);
        i_rst = 1'b0;
        cyc(4);
        chk_pin(16'(switching_frequency_setting), 16'(strap));
        chk_pin(16'(en), 16'h00FF);
        foreach (ra[i]) rd_reg(ra[i], rv[i]);
        rd_reg(PZPS_REG_FSW, strap);
        wr_reg(PZPS_REG_FSW, 8'h5A);
        cyc(2);
        chk_pin(16'(switching_frequency_setting), 16'h005A);
        wr_reg(PZPS_REG_HYST, 8'h10);
        rd_reg(PZPS_REG_HYST, 8'h10);
        for (int k = 0; k < 4; k++) begin
            wr_reg(PZPS_REG_LOAD_LINE, 8'h80 | 8'(k));
            cyc(2);
            chk_pin(16'(droop), 16'(dpct[k]));
            chk_pin(16'(coef), 16'(k));
        end
        wr_reg(PZPS_REG_LOAD_LINE, 8'h03);
        cyc(2);
        chk_pin(16'(droop), 16'h0000);
        power_saving_input = 2'h0;
        wr_reg(PZPS_REG_SHED_DLY, 8'h00);
        for (int p = 1; p <= 8; p++) begin
            for (int z = 0; z < 5; z++) begin
                pcnt = 4'(p);
                wr_reg(PZPS_REG_LPC, 8'(z));
                cyc(12);
                chk_pin(16'(zone), 16'(mdl_zone(p, z)));
                chk_pin(16'(en), 16'(mdl_mask(p, mdl_zone(p, z))));
            end
        end
        wr_reg(PZPS_REG_FAST_DROP, 8'h01);
        drop = 1'b1;
        cyc(1);
        drop = 1'b0;
        cyc(5);
        chk_pin(16'({boost, en}), 16'h01FF);
        cyc(47);
        chk_pin(16'({boost, en}), 16'h01FF);
        cyc(1);
        chk_pin(16'({boost, en}), 16'h0001);
        for (int t = 0; t < 4; t++) begin
            wr_reg(PZPS_REG_THR_BASE + 8'(t), (t == 3) ? 8'hC0 : 8'(8'h20 << t));
        end
        wr_reg(PZPS_REG_SHED_DLY, 8'h02);
        mon = 1'b1;
        iout = 8'($urandom % 16);
        power_saving_input = 2'h1;
        cyc(3000);
        chk_pin(16'(zone), 16'h0000);
        vnom = 1'b1;
        wait_zone(3'h1, 8000);
        cyc(1);
        chk_pin(16'(en), 16'h0055);
        gap = 1;
        while (zone !== 3'h2 && gap < 9000) begin
            @(negedge i_clock);
            gap++;
        end
        chk_pin(16'(gap), 16'(2 * PZPS_SHED_STEP_CYC + 1));
        iout = 8'h38;
        cyc(6000);
        chk_pin(16'(zone), 16'h0002);
        iout = 8'hC1 + 8'($urandom % 62);
        wait_zone(3'h0, 2700);
        chk_pin(16'(zone), 16'h0000);
        rd_reg(PZPS_REG_STATUS, 8'h08);
        complete_run;
    end
endmodule
